// ==== src/sfx_pkg.sv ====
// Purpose: constants, register map and strap helpers for the external fifo controller
// Assumes: one 200 MHz clock shared with the fifo devices
// Notes: offsets are byte addresses on a 32-bit classic wishbone bus
`default_nettype none
package sfx_pkg;
	localparam int CLK_PERIOD_NS = 5;
	// device reset pulse and recovery before the first access
	localparam int RST_HOLD_NS = 40;
	localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_RECOV_NS = 40;
	localparam int RST_RECOV_CYC = (RST_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// pin synchroniser depth, flag latency inside the device and one slip cycle for missed skew
	localparam int SYNC_CYC = 2;
	localparam int FLAG_LAT_CYC = 3;
	localparam int SKEW_SLIP_CYC = 1;
	localparam int SETTLE_CYC = SYNC_CYC + FLAG_LAT_CYC + SKEW_SLIP_CYC;
	localparam int Q_LAT_CYC = SYNC_CYC + 2;
	localparam int RIPPLE_PER_DEV = 4;
	localparam int RIPPLE_LAST = 3;
	// register offsets
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam logic [7:0] ADR_DATA = 8'h08;
	localparam logic [7:0] ADR_CAP = 8'h0c;
	// ctrl fields
	localparam int CTRL_STRAP_LSB = 0;
	localparam int CTRL_TOPO_LSB = 3;
	localparam int CTRL_START_BIT = 8;
	localparam int STAT_ERR_BIT = 10;
	localparam logic [2:0] STRAP_RST = 3'h0;
	// cascade topology
	localparam logic [1:0] TOPO_SINGLE = 2'h0;
	localparam logic [1:0] TOPO_DAISY = 2'h1;
	localparam logic [1:0] TOPO_SERIES = 2'h2;

	typedef enum logic [2:0] {
		S_RST_HOLD,
		S_RST_WAIT,
		S_IDLE,
		S_WR,
		S_RD,
		S_RD_Q,
		S_SETTLE
	} sfx_state_t;

	// strap triple is {first_load, read_chain_in, write_chain_in}
	function automatic logic sfx_is_fall_through_mode(input logic [2:0] t);
		return (t == 3'h1) || (t == 3'h5);
	endfunction : sfx_is_fall_through_mode

	function automatic logic sfx_is_sync_part(input logic [2:0] t);
		return (t == 3'h4) || (t == 3'h5) || (t == 3'h6);
	endfunction : sfx_is_sync_part

	function automatic logic sfx_is_double(input logic [2:0] t);
		return (t == 3'h2) || (t == 3'h6);
	endfunction : sfx_is_double

	function automatic logic sfx_is_single(input logic [2:0] t);
		return (t != 3'h3) && (t != 3'h7);
	endfunction : sfx_is_single

	// a series chain only works with every device in fall-through
	function automatic logic [2:0] sfx_apply_strap(input logic [2:0] req, input logic [1:0] topo);
		return (topo == TOPO_SERIES) ? {req[2], 2'h1} : req;
	endfunction : sfx_apply_strap
endpackage : sfx_pkg
`default_nettype wire

// ==== src/sfx_sync.sv ====
// Purpose: two flip-flop synchroniser for a group of pin inputs
// Assumes: each bit is an independent level
// Notes: the first stage is read only by the second
`default_nettype none
module sfx_sync
	import sfx_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : sfx_sync
`default_nettype wire

// ==== src/sfx_ctrl.sv ====
// Purpose: host controller for one or more external synchronous fifo devices
// Assumes: device clocks are ref_clk; flag and data pins still pass two flops
// Notes: software reaches ctrl, status, data and capacity over classic wishbone
//
// Summary of operation
// - single-device strap triples are 000,001,010,100,101,110 held during reset
// - width expansion: shared controls, partial flags from one, gated empty/full
// - daisy chain: first device first-load low, all others high
// - daisy chain: chain outputs feed next device chain inputs
// - daisy chain: offset-load inputs all connected in common
// - daisy chain: composite flags are OR of each device flag
// - series chain: output bus feeds next input, capacity sums depths
// - series chain: every device in fall-through at master reset
// - series chain: read clocks run continuously
// - never tie output controls of different devices together; here dev_oe_n and dev_ren_n are single pins shared by every device
// - straps stay static during operation
`default_nettype none
module sfx_ctrl
	import sfx_pkg::*;
#(
	parameter int DW = 18,
	parameter int NDEV = 1,
	parameter int DEPTH = 512,
	parameter int WAIT_CYC = 1024
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic dev_rst_n,
	output logic dev_wclk,
	output logic dev_rclk,
	output logic dev_wen_n,
	output logic dev_ren_n,
	output logic dev_oe_n,
	output logic offset_load_n,
	output logic [DW-1:0] dev_data_o,
	input wire logic [DW-1:0] dev_q_i,
	output logic [NDEV-1:0] first_load_select,
	output logic read_chain_in,
	output logic write_chain_in,
	input wire logic [NDEV-1:0] empty_flag_n,
	input wire logic [NDEV-1:0] full_flag_n,
	input wire logic [NDEV-1:0] almost_empty_flag,
	input wire logic [NDEV-1:0] almost_full_flag,
	input wire logic half_full_flag
);
	localparam int SW = 4 * NDEV + 1 + DW;
	localparam int RIPPLE_CYC = (NDEV - 1) * RIPPLE_PER_DEV + RIPPLE_LAST + SKEW_SLIP_CYC + SYNC_CYC;
	localparam int RD_TMO_CYC = RIPPLE_CYC + WAIT_CYC;
	localparam logic [15:0] RST_HOLD_LAST = 16'(RST_HOLD_CYC - 1);
	localparam logic [15:0] RST_RECOV_LAST = 16'(RST_RECOV_CYC - 1);
	localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYC - 1);
	localparam logic [15:0] Q_LAST = 16'(Q_LAT_CYC - 1);
	localparam logic [15:0] WR_TMO_LAST = 16'(WAIT_CYC - 1);
	localparam logic [15:0] RD_TMO_LAST = 16'(RD_TMO_CYC - 1);

	typedef struct packed {
		sfx_state_t st;
		logic [15:0] cnt;
		logic [2:0] req;
		logic [1:0] topo;
		logic [2:0] strap;
		logic [2:0] mode;
		logic err;
		logic ack;
		logic [31:0] dat;
		logic wen_n;
		logic ren_n;
		logic rst_n;
		logic [DW-1:0] wdata;
	} sfx_regs_t;

	sfx_regs_t s_r;
	sfx_regs_t s_nxt;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and composite flags

	logic [SW-1:0] sync_q;
	logic [NDEV-1:0] e_s;
	logic [NDEV-1:0] f_s;
	logic [NDEV-1:0] ae_s;
	logic [NDEV-1:0] af_s;
	logic hf_s;
	logic [DW-1:0] q_s;
	logic [NDEV-1:0] hd;
	logic [NDEV-1:0] sp;
	logic fall_through_mode;
	logic avail;
	logic space;
	logic ae;
	logic af;
	logic hf;
	logic [31:0] cap;
	logic [31:0] status;
	logic acc;

	sfx_sync #(.W(SW)) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.d({dev_q_i, half_full_flag, almost_full_flag, almost_empty_flag, full_flag_n, empty_flag_n}),
		.q(sync_q)
	);

	assign {q_s, hf_s, af_s, ae_s, f_s, e_s} = sync_q;
	assign fall_through_mode = sfx_is_fall_through_mode(s_r.mode);

	genvar g;
	generate
		for (g = 0; g < NDEV; g++) begin : g_dev
			// output-ready and input-ready are active low, empty and full flags active high for data
			assign hd[g] = fall_through_mode ? ~e_s[g] : e_s[g];
			assign sp[g] = fall_through_mode ? ~f_s[g] : f_s[g];
			assign first_load_select[g] = (s_r.topo == TOPO_DAISY) ? (g != 0) : s_r.strap[2];
		end
	endgenerate

	// each device's empty, full and partial flags arrive on their own pins; half-full has one shared pin
	always_comb begin
		avail = &hd;
		space = &sp;
		ae = ~ae_s[0];
		af = ~af_s[0];
		hf = ~hf_s;
		cap = 32'(DEPTH);
		case (s_r.topo)
			TOPO_DAISY: begin
				avail = |hd;
				space = |sp;
				ae = ~(|ae_s);
				af = ~(|af_s);
				hf = 1'b0;
				cap = 32'(NDEV * DEPTH);
			end
			TOPO_SERIES: begin
				avail = hd[NDEV-1];
				space = sp[0];
				ae = ~ae_s[NDEV-1];
				af = ~af_s[0];
				cap = 32'(NDEV * (DEPTH + 1));
			end
			default: begin
				if (fall_through_mode) begin
					cap = 32'(DEPTH + 1);
				end
			end
		endcase
	end

	assign status = {21'h0, s_r.err, sfx_is_single(s_r.mode), sfx_is_double(s_r.mode),
		sfx_is_sync_part(s_r.mode), fall_through_mode, hf, af, ae, space, avail, (s_r.st != S_RST_HOLD) && (s_r.st != S_RST_WAIT)};

	////////////////////////////////////////////////////////////////////////////
	// control state machine and register slave

	// one shared clock means the device read clock free-runs with ref_clk
	assign dev_wclk = ref_clk;
	assign dev_rclk = ref_clk;
	assign acc = wb_cyc_i & wb_stb_i & ~s_r.ack;

	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		s_nxt.wen_n = 1'b1;
		s_nxt.ren_n = 1'b1;
		case (s_r.st)
			S_RST_HOLD: begin
				s_nxt.rst_n = 1'b0;
				if (s_r.cnt == RST_HOLD_LAST) begin
					s_nxt.rst_n = 1'b1;
					s_nxt.mode = s_r.strap;
					s_nxt.cnt = '0;
					s_nxt.st = S_RST_WAIT;
				end else begin
					s_nxt.cnt = s_r.cnt + 16'h1;
				end
			end
			S_RST_WAIT: begin
				if (s_r.cnt == RST_RECOV_LAST) begin
					s_nxt.st = S_IDLE;
				end else begin
					s_nxt.cnt = s_r.cnt + 16'h1;
				end
			end
			S_IDLE: begin
				if (acc) begin
					s_nxt.ack = 1'b1;
					s_nxt.dat = '0;
					s_nxt.cnt = '0;
					case (wb_adr_i)
						ADR_CTRL: begin
							if (wb_we_i) begin
								if (wb_sel_i[0]) begin
									s_nxt.req = wb_dat_i[CTRL_STRAP_LSB+:3];
								end
								// straps and topology only move inside a device reset
								if (wb_sel_i[1] && wb_dat_i[CTRL_START_BIT]) begin
									s_nxt.topo = wb_sel_i[0] ? wb_dat_i[CTRL_TOPO_LSB+:2] : s_r.topo;
									s_nxt.strap = sfx_apply_strap(s_nxt.req, s_nxt.topo);
									s_nxt.rst_n = 1'b0;
									s_nxt.st = S_RST_HOLD;
								end
							end else begin
								s_nxt.dat = {24'h0, s_r.topo, s_r.mode, s_r.req};
							end
						end
						ADR_STATUS: begin
							if (wb_we_i) begin
								if (wb_sel_i[1] && wb_dat_i[STAT_ERR_BIT]) begin
									s_nxt.err = 1'b0;
								end
							end else begin
								s_nxt.dat = status;
							end
						end
						ADR_DATA: begin
							s_nxt.ack = 1'b0;
							if (wb_we_i) begin
								s_nxt.wdata = wb_dat_i[DW-1:0];
								s_nxt.st = S_WR;
							end else begin
								s_nxt.st = S_RD;
							end
						end
						ADR_CAP: begin
							if (!wb_we_i) begin
								s_nxt.dat = cap;
							end
						end
						default: begin
						end
					endcase
				end
			end
			S_WR: begin
				if (space) begin
					s_nxt.wen_n = 1'b0;
					s_nxt.cnt = '0;
					s_nxt.st = S_SETTLE;
				end else if (s_r.cnt == WR_TMO_LAST) begin
					s_nxt.err = 1'b1;
					s_nxt.cnt = '0;
					s_nxt.st = S_SETTLE;
				end else begin
					s_nxt.cnt = s_r.cnt + 16'h1;
				end
			end
			S_RD: begin
				if (avail) begin
					s_nxt.ren_n = 1'b0;
					s_nxt.cnt = '0;
					if (fall_through_mode) begin
						// fall-through word already sits on the outputs; the read advances it
						s_nxt.dat = 32'(q_s);
						s_nxt.st = S_SETTLE;
					end else begin
						s_nxt.st = S_RD_Q;
					end
				end else if (s_r.cnt == RD_TMO_LAST) begin
					// wait covers the first-word ripple through a series chain
					s_nxt.err = 1'b1;
					s_nxt.cnt = '0;
					s_nxt.st = S_SETTLE;
				end else begin
					s_nxt.cnt = s_r.cnt + 16'h1;
				end
			end
			S_RD_Q: begin
				if (s_r.cnt == Q_LAST) begin
					s_nxt.dat = 32'(q_s);
					s_nxt.cnt = '0;
					s_nxt.st = S_SETTLE;
				end else begin
					s_nxt.cnt = s_r.cnt + 16'h1;
				end
			end
			S_SETTLE: begin
				// flags may lag a full extra cycle on tight skew, so wait them out
				if (s_r.cnt == SETTLE_LAST) begin
					s_nxt.ack = 1'b1;
					s_nxt.st = S_IDLE;
				end else begin
					s_nxt.cnt = s_r.cnt + 16'h1;
				end
			end
			default: begin
				s_nxt.st = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_r <= '0;
			s_r.st <= S_RST_HOLD;
			s_r.wen_n <= 1'b1;
			s_r.ren_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign wb_ack_o = s_r.ack;
	assign wb_dat_o = s_r.dat;
	assign dev_rst_n = s_r.rst_n;
	assign dev_wen_n = s_r.wen_n;
	assign dev_ren_n = s_r.ren_n;
	assign dev_oe_n = 1'b0;
	assign offset_load_n = 1'b1; // one common offset-load line for every device
	assign dev_data_o = s_r.wdata;
	// in a daisy chain these two inputs come from the previous device instead
	assign read_chain_in = s_r.strap[1];
	assign write_chain_in = s_r.strap[0];

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	a_rst_pulse_len: assert property ($fell(dev_rst_n) |-> !dev_rst_n [*8])
		else $error("device reset pulse too short");
	a_mode_latch: assert property ($rose(dev_rst_n) && s_r.topo != TOPO_DAISY |->
		s_r.mode == {first_load_select[0], read_chain_in, write_chain_in}) else $error("mode not latched from straps");
	a_straps_static: assert property (dev_rst_n && $past(dev_rst_n) |->
		$stable({first_load_select, read_chain_in, write_chain_in})) else $error("straps moved outside reset");
	a_series_fall_through_mode: assert property (s_r.topo == TOPO_SERIES && !dev_rst_n |-> sfx_is_fall_through_mode(s_r.strap))
		else $error("series chain reset without fall-through straps");
	a_first_load: assert property (s_r.topo == TOPO_DAISY |-> first_load_select == ~NDEV'(1))
		else $error("first-load straps wrong in daisy chain");
	a_hf_masked: assert property (s_r.topo == TOPO_DAISY |-> !status[5]) else $error("half-full in daisy");
	a_wen_space: assert property ($fell(dev_wen_n) |-> $past(space) ##1 dev_wen_n) else $error("write strobe");
	a_ren_avail: assert property ($fell(dev_ren_n) |-> $past(avail) ##1 dev_ren_n) else $error("read strobe");
	a_settle_ack: assert property ($fell(dev_wen_n) |-> !wb_ack_o [*6] ##1 wb_ack_o)
		else $error("write acknowledged before flags settled");
	a_fall_through_mode_cap: assert property (s_r.topo == TOPO_SINGLE && fall_through_mode |-> cap == 32'(DEPTH + 1))
		else $error("fall-through capacity wrong");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held more than one cycle");
	c_write_done: cover property ($fell(dev_wen_n) ##[1:10] wb_ack_o);
	c_read_done: cover property ($fell(dev_ren_n) ##[1:20] wb_ack_o);
	c_timeout: cover property ($rose(s_r.err));
	c_reset_seq: cover property ($rose(dev_rst_n) ##[1:20] s_r.st == S_IDLE);
endmodule : sfx_ctrl
`default_nettype wire

// ==== testbench/sfx_dev_model.sv ====
// Purpose: behavioural fifo device facing the controller pins
// Assumes: write and read side both run on the write clock pin
// Notes: partial and half flags active low; offsets are plain defaults
`default_nettype none
module sfx_dev_model #(
	parameter int DW = 18,
	parameter int DEPTH = 4,
	parameter int AE_OFF = 1,
	parameter int AF_OFF = 1
) (
	input wire logic wclk,
	input wire logic rst_n,
	input wire logic wen_n,
	input wire logic ren_n,
	input wire logic [DW-1:0] d,
	output logic [DW-1:0] q,
	input wire logic [2:0] strap,
	output logic empty_flag_n,
	output logic full_flag_n,
	output logic almost_empty_flag,
	output logic almost_full_flag,
	output logic half_full_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DW-1:0] fq[$];
	logic fall_through_mode;
	logic daisy;
	int cap;
	assign cap = fall_through_mode ? DEPTH + 1 : DEPTH;
	////////////////////////////////////////////////////////////////////////////////
	// straps are sampled every reset cycle, so the value at release is what sticks
	always @(posedge wclk) begin
		if (!rst_n) begin
			fq.delete();
			fall_through_mode <= (strap == 3'h1) || (strap == 3'h5);
			daisy <= (strap == 3'h3) || (strap == 3'h7);
		end else begin
			if (!ren_n && fq.size() > 0) begin
				if (!fall_through_mode) q <= fq[0];
				void'(fq.pop_front());
			end
			if (!wen_n && fq.size() < cap) fq.push_back(d);
			if (fall_through_mode && fq.size() > 0) q <= fq[0];
		end
		// flags are registered on the same edge that updates the count, with no extra lag
		empty_flag_n <= fall_through_mode ? (fq.size() == 0) : (fq.size() != 0);
		full_flag_n <= fall_through_mode ? (fq.size() == cap) : (fq.size() != cap);
		almost_empty_flag <= !(fq.size() <= AE_OFF);
		almost_full_flag <= !(fq.size() >= cap - AF_OFF);
		// no half-full in a chain: the pin wanders so nobody may trust it
		half_full_flag <= daisy ? !half_full_flag : !(fq.size() > cap / 2);
	end
endmodule : sfx_dev_model
`default_nettype wire

// ==== testbench/sync_fifo_flags_and_expansion_tb.sv ====
// Purpose: self-checking bench for the external fifo controller
// Assumes: one device, shallow depth and short timeout keep fills quick
// Notes: the device model answers on the pins
`default_nettype none
module sync_fifo_flags_and_expansion_tb
	import sfx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DEP = 4;
	localparam logic [7:0] FW = 8'h22;
	localparam logic [7:0] SY = 8'h70;
	localparam logic [7:0] DB = 8'h44;
	localparam logic [7:0] SG = 8'h77;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] wb_dat;
	logic wb_ack, drst_n, wclk, wen_n, ren_n, rci, wci, hff, oln, oen;
	logic [17:0] dq, dd;
	logic [0:0] fls, efn, ffn, aef, aff;
	int error_cnt = 0;
	int num_checks = 0;

	sfx_ctrl #(.DW(18), .NDEV(1), .DEPTH(DEP), .WAIT_CYC(16)) u_dut (
		.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .dev_rst_n(drst_n),
		.dev_wclk(wclk), .dev_rclk(), .dev_wen_n(wen_n), .dev_ren_n(ren_n), .dev_oe_n(oen),
		.offset_load_n(oln), .dev_data_o(dd), .dev_q_i(dq), .first_load_select(fls),
		.read_chain_in(rci), .write_chain_in(wci), .empty_flag_n(efn), .full_flag_n(ffn),
		.almost_empty_flag(aef), .almost_full_flag(aff), .half_full_flag(hff));
	sfx_dev_model #(.DW(18), .DEPTH(DEP)) u_dev (
		.wclk(wclk), .rst_n(drst_n), .wen_n(wen_n), .ren_n(ren_n), .d(dd), .q(dq),
		.strap({fls, rci, wci}), .empty_flag_n(efn), .full_flag_n(ffn), .almost_empty_flag(aef),
		.almost_full_flag(aff), .half_full_flag(hff));

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// classic cycle: hold everything until the ack edge, take data there
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// no cycle count is assumed; only the watchdog ends a hung access
		do begin
			@(posedge ref_clk);
		end while (wb_ack !== 1'b1);
		rdat = wb_dat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic cfg(input logic [2:0] s, input logic [1:0] tp);
		wb(1'b1, ADR_CTRL, (32'h1 << CTRL_START_BIT) | {27'h0, tp, s});
		for (int i = 0; i < 40; i++) begin
			wb(1'b0, ADR_STATUS, 32'h0);
			if (rdat[0] === 1'b1) break;
		end
	endtask : cfg
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_modes;
		for (int t = 0; t < 8; t++) begin
			cfg(3'(t), TOPO_SINGLE);
			chk("strap pins", 32'({fls, rci, wci}), 32'(t));
			wb(1'b0, ADR_STATUS, 32'h0);
			chk("mode", 32'(rdat[9:6]), 32'({SG[t], DB[t], SY[t], FW[t]}));
			wb(1'b0, ADR_CTRL, 32'h0);
			chk("latched", 32'(rdat[5:3]), 32'(t));
			wb(1'b0, ADR_CAP, 32'h0);
			chk("cap", rdat, 32'(FW[t] ? DEP + 1 : DEP));
		end
	endtask : t_modes

	task automatic t_latch;
		cfg(3'h5, TOPO_SINGLE);
		wb(1'b1, ADR_CTRL, 32'h0a);
		chk("kept pin", 32'(fls), 32'h1);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk("kept mode", 32'(rdat[8:6]), 32'h3);
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("kept ctrl", 32'(rdat[7:0]), 32'h2a);
	endtask : t_latch

	task automatic t_data(input logic [2:0] s);
		int n;
		cfg(s, TOPO_SINGLE);
		n = FW[s] ? DEP + 1 : DEP;
		for (int i = 0; i < n; i++) wb(1'b1, ADR_DATA, 32'h1230 + i);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk("full flags", 32'(rdat[5:1]), 32'h19);
		wb(1'b1, ADR_DATA, 32'h3ffff);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk("overflow", 32'(rdat[10]), 32'h1);
		wb(1'b1, ADR_STATUS, 32'h400);
		for (int i = 0; i < n; i++) begin
			wb(1'b0, ADR_DATA, 32'h0);
			chk("pop", rdat, 32'h1230 + i);
		end
		wb(1'b0, ADR_STATUS, 32'h0);
		chk("empty flags", 32'({rdat[10], rdat[5:1]}), 32'h06);
		wb(1'b0, ADR_DATA, 32'h0);
		chk("underflow", rdat, 32'h0);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk("underflow err", 32'(rdat[10]), 32'h1);
		wb(1'b1, ADR_STATUS, 32'h400);
	endtask : t_data

	task automatic t_topo;
		cfg(3'h3, TOPO_DAISY);
		chk("first load", 32'(fls), 32'h0);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk("daisy flags", 32'(rdat[8:5]), 32'h0);
		wb(1'b0, ADR_CAP, 32'h0);
		chk("daisy cap", rdat, 32'(DEP));
		cfg(3'h4, TOPO_SERIES);
		chk("series straps", 32'({fls, rci, wci}), 32'h5);
		wb(1'b0, ADR_CAP, 32'h0);
		chk("series cap", rdat, 32'(DEP + 1));
		wb(1'b1, ADR_DATA, 32'h2b);
		wb(1'b0, ADR_DATA, 32'h0);
		chk("series word", rdat, 32'h2b);
	endtask : t_topo

	task automatic t_misc;
		wb(1'b0, 8'h10, 32'h0);
		chk("unmapped", rdat, 32'h0);
		wb(1'b1, ADR_CAP, 32'h7);
		wb(1'b0, ADR_CAP, 32'h0);
		chk("cap ro", rdat, 32'(DEP + 1));
		chk("load pin", 32'(oln), 32'h1);
		chk("oe pin", 32'(oen), 32'h0);
	endtask : t_misc

	task automatic results;
		if (error_cnt == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("reset ctrl", rdat, 32'h0);
		t_modes();
		t_latch();
		t_data(3'h0);
		t_data(3'h5);
		t_data(3'h6);
		t_topo();
		t_misc();
		results();
	end

	// the whole run needs about a thousand cycles; this leaves ample slack
	initial begin
		repeat (40000) @(posedge ref_clk);
		error_cnt++;
		results();
	end
endmodule : sync_fifo_flags_and_expansion_tb
`default_nettype wire
